// file: src/iss_pkg.sv
// Constants, register map and carrier types of the interrupt source steering block.
// Assumes one 50 MHz clock and a 32-bit classic Wishbone register bus.
package iss_pkg;

   // ==========================================================
   // Sizes
   localparam int NUM_SRC = 80;
   localparam int NUM_CH  = 4;
   localparam int XCE_NUM = 5;
   localparam int XCE_W   = 16;
   localparam int SEL_W   = 7;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_SEL_BASE  = 8'h00;
   localparam logic [7:0] OFF_MODE_BASE = 8'h10;
   localparam logic [7:0] OFF_XCE_BASE  = 8'h20;
   localparam logic [7:0] OFF_XCE_GONE  = 8'h34;
   localparam logic [7:0] OFF_BSIZE     = 8'h38;
   localparam logic [7:0] OFF_STAT      = 8'h3c;
   localparam logic [7:0] OFF_MASK      = 8'h40;

   // ==========================================================
   // Channel mode field positions and reset values
   localparam int MODE_CAP_BIT  = 0;
   localparam int MODE_EN_BIT   = 1;
   localparam int MODE_LOW_BIT  = 2;
   localparam int MODE_HIGH_BIT = 3;
   localparam logic [31:0]      RST_BSIZE = 32'h0000_0000;
   localparam logic [XCE_W-1:0] RST_XCE   = 16'h0000;
   localparam logic [SEL_W-1:0] RST_SEL   = 7'h00;
   localparam logic [NUM_CH-1:0] RST_STAT = 4'h0;
   localparam logic [NUM_CH-1:0] RST_MASK = 4'h0;

   typedef struct packed {
      logic transfer_source_field_high;
      logic transfer_source_field_low;
      logic channel_transfer_enable;
      logic source_capture_bit;
   } iss_mode_type;

   localparam iss_mode_type RST_MODE = '0;

endpackage

// file: src/iss_chan_route.sv
// One channel of the steering block: source multiplexer and claim decode.
// Assumes sources are synchronous to clk_i.
`timescale 1ns/100ps
module iss_chan_route
   import iss_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic [NUM_SRC-1:0] src_i,
   input  wire logic [SEL_W-1:0]   sel_i,
   input  wire iss_mode_type       mode_i,
   output logic                    act_o,
   output logic [NUM_SRC-1:0]      claim_o
);

   // ==========================================================
   // Selection
   // Out-of-range selections pick no source rather than an unknown one.
   wire sel_ok   = ({25'h0, sel_i} < NUM_SRC);
   wire sel_src  = sel_ok & src_i[sel_i];
   wire on_chip  = mode_i.transfer_source_field_high &
                   ~mode_i.transfer_source_field_low &
                   mode_i.channel_transfer_enable;
   wire claiming = on_chip & mode_i.source_capture_bit & sel_ok;
   wire [NUM_SRC-1:0] one_hot = {{(NUM_SRC-1){1'b0}}, 1'b1} << sel_i;
   logic act_reg;

   assign claim_o = claiming ? one_hot : '0;
   assign act_o   = act_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_reg <= 1'b0;
      end else begin
         act_reg <= sel_src & on_chip;
      end
   end

   chk_chan_act: assert property (@(posedge clk_i) disable iff (rst_i)
      1 |=> act_o == $past(sel_ok && src_i[sel_i] && on_chip))
      else $error("Channel activation does not follow selected source.");

endmodule

// file: src/iss_top.sv
// Interrupt source steering: DMA claim, transfer controller and CPU routes.
// Assumes sources are level requests on clk_i and a classic Wishbone master.
`timescale 1ns/100ps
module iss_top
   import iss_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic [31:0]             wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic [NUM_SRC-1:0] src_irq_i,
   output logic [NUM_CH-1:0]       dma_req_o,
   output logic [NUM_SRC-1:0]      xfer_req_o,
   output logic [NUM_SRC-1:0]      cpu_req_o,
   output logic [31:0]             block_size_o,
   output logic                    irq_o
);

   // ==========================================================
   // Registers
   logic [SEL_W-1:0]   sel_reg  [NUM_CH];
   iss_mode_type       mode_reg [NUM_CH];
   logic [XCE_W-1:0]   xce_reg  [XCE_NUM];
   logic [31:0]        bsize_reg;
   logic [NUM_CH-1:0]  stat_reg;
   logic [NUM_CH-1:0]  mask_reg;
   logic [NUM_CH-1:0]  act_prev_reg;
   logic               ack_reg;
   logic [31:0]        rdat_reg;
   logic [NUM_SRC-1:0] xfer_reg;
   logic [NUM_SRC-1:0] cpu_reg;
   logic               irq_reg;

   // ==========================================================
   // Bus decode
   // Ack drops for a cycle after each answer, so a request held through ack is not taken twice.
   wire        req     = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire        wr_go   = req & wb_we_i;
   wire [5:0]  word    = wb_adr_i[7:2];
   wire [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] wr_bits = wb_dat_i & wmask;
   wire        hit_bsize = wb_adr_i == OFF_BSIZE;
   wire        hit_stat  = wb_adr_i == OFF_STAT;
   wire        hit_mask  = wb_adr_i == OFF_MASK;
   wire [5:0]  sel_w   = OFF_SEL_BASE[7:2];
   wire [5:0]  mode_w  = OFF_MODE_BASE[7:2];
   wire [5:0]  xce_w   = OFF_XCE_BASE[7:2];

   // ==========================================================
   // Per-channel routing
   wire [NUM_SRC-1:0] claim [NUM_CH];
   wire [NUM_CH-1:0]  act;
   logic [NUM_SRC-1:0] claim_all;
   wire [NUM_SRC-1:0]  en_flat;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         iss_chan_route u_route (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .src_i   (src_irq_i),
            .sel_i   (sel_reg[g]),
            .mode_i  (mode_reg[g]),
            .act_o   (act[g]),
            .claim_o (claim[g])
         );
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               sel_reg[g]  <= RST_SEL;
               mode_reg[g] <= RST_MODE;
            end else if (wr_go && word == sel_w + 6'(g)) begin
               sel_reg[g]  <= (sel_reg[g] & ~wmask[SEL_W-1:0]) | wr_bits[SEL_W-1:0];
            end else if (wr_go && word == mode_w + 6'(g)) begin
               mode_reg[g] <= (mode_reg[g] & ~wmask[3:0]) | wr_bits[3:0];
            end
         end
      end
      for (g = 0; g < XCE_NUM; g++) begin : g_xce
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               xce_reg[g] <= RST_XCE;
            end else if (wr_go && word == xce_w + 6'(g)) begin
               xce_reg[g] <= (xce_reg[g] & ~wmask[XCE_W-1:0]) | wr_bits[XCE_W-1:0];
            end
         end
         assign en_flat[g*XCE_W +: XCE_W] = xce_reg[g];
      end
   endgenerate

   always_comb begin
      claim_all = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         claim_all = claim_all | claim[i];
      end
   end

   // A claimed source is masked before the split, so it can never reach either route.
   wire [NUM_SRC-1:0] free_src  = src_irq_i & ~claim_all;
   wire [NUM_SRC-1:0] xfer_next = free_src & en_flat;
   wire [NUM_SRC-1:0] cpu_next  = free_src & ~en_flat;

   // ==========================================================
   // Status, mask and interrupt
   // A new activation in the clearing cycle survives: set wins over clear.
   wire [NUM_CH-1:0] ev        = act & ~act_prev_reg;
   wire [NUM_CH-1:0] clr       = (wr_go && hit_stat) ? wr_bits[NUM_CH-1:0] : '0;
   wire [NUM_CH-1:0] stat_next = (stat_reg & ~clr) | ev;
   // The interrupt uses the next mask, so it follows a mask write with no extra cycle.
   wire [NUM_CH-1:0] mask_next = (wr_go && hit_mask) ?
                                 ((mask_reg & ~wmask[NUM_CH-1:0]) | wr_bits[NUM_CH-1:0]) :
                                 mask_reg;

   // ==========================================================
   // Read mux
   // Unmapped words, the removed sixth enable slot among them, read as zero.
   logic [31:0] rd_next;
   always_comb begin
      rd_next = 32'h0000_0000;
      if (word >= sel_w && word < sel_w + 6'(NUM_CH)) begin
         rd_next = {25'h0, sel_reg[word[1:0]]};
      end else if (word >= mode_w && word < mode_w + 6'(NUM_CH)) begin
         rd_next = {28'h0, mode_reg[word[1:0]]};
      end else if (word >= xce_w && word < xce_w + 6'(XCE_NUM)) begin
         rd_next = {16'h0, xce_reg[3'(word - xce_w)]};
      end else if (hit_bsize) begin
         rd_next = bsize_reg;
      end else if (hit_stat) begin
         rd_next = {28'h0, stat_reg};
      end else if (hit_mask) begin
         rd_next = {28'h0, mask_reg};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bsize_reg <= RST_BSIZE;
         mask_reg  <= RST_MASK;
      end else if (wr_go && hit_bsize) begin
         bsize_reg <= (bsize_reg & ~wmask) | wr_bits;
      end else if (wr_go && hit_mask) begin
         mask_reg  <= mask_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg      <= 1'b0;
         rdat_reg     <= 32'h0000_0000;
         stat_reg     <= RST_STAT;
         act_prev_reg <= '0;
         xfer_reg     <= '0;
         cpu_reg      <= '0;
         irq_reg      <= 1'b0;
      end else begin
         ack_reg      <= req;
         rdat_reg     <= req ? rd_next : 32'h0000_0000;
         stat_reg     <= stat_next;
         act_prev_reg <= act;
         xfer_reg     <= xfer_next;
         cpu_reg      <= cpu_next;
         irq_reg      <= |(stat_next & mask_next);
      end
   end

   assign wb_ack_o     = ack_reg;
   assign wb_dat_o     = rdat_reg;
   assign dma_req_o    = act;
   assign xfer_req_o   = xfer_reg;
   assign cpu_req_o    = cpu_reg;
   assign block_size_o = bsize_reg;
   assign irq_o        = irq_reg;

   // ==========================================================
   // Checks
   chk_claim_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
      1 |=> ((xfer_req_o | cpu_req_o) & $past(claim_all)) == '0)
      else $error("Claimed source leaked to transfer controller or CPU.");

   chk_cpu_route: assert property (@(posedge clk_i) disable iff (rst_i)
      1 |=> cpu_req_o == $past(src_irq_i & ~claim_all & ~en_flat))
      else $error("CPU route does not match unclaimed disabled sources.");

   chk_xfer_route: assert property (@(posedge clk_i) disable iff (rst_i)
      1 |=> xfer_req_o == $past(src_irq_i & ~claim_all & en_flat))
      else $error("Transfer route does not match unclaimed enabled sources.");

   chk_xce_gone_read: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && !wb_we_i && wb_adr_i == OFF_XCE_GONE |-> wb_dat_o == 32'h0000_0000)
      else $error("Removed enable register slot did not read zero.");

   chk_bsize_reset: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> bsize_reg == 32'h0000_0000)
      else $error("Block size register not zero after reset.");

   chk_route_split: assert property (@(posedge clk_i) disable iff (rst_i)
      1 |=> (xfer_req_o & cpu_req_o) == '0)
      else $error("Source driven on both routes.");

   chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o == |(stat_reg & mask_reg))
      else $error("Interrupt output does not follow unmasked status.");

   chk_stat_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      1 |=> ($past(ev) & ~stat_reg) == '0)
      else $error("Status bit lost an activation edge.");

   chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("Bus acknowledge stood longer than one cycle.");

endmodule

// file: tb/iss_src_model.sv
// Model of the peripheral interrupt sources that face the steering block.
// Assumes one clock; each level changes only just after a rising edge.
`timescale 1ns/100ps
module iss_src_model
   import iss_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               set_i,
   input  wire logic [6:0]         idx_i,
   input  wire logic               lvl_i,
   output logic [NUM_SRC-1:0]      src_o
);
   // A peripheral flag holds its level until its own logic changes it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_o <= '0;
      end else if (set_i) begin
         src_o[idx_i] <= lvl_i;
      end
   end
endmodule

// file: tb/iss_top_tb_top.sv
// Self-checking bench for the steering block with two queues of expected results.
// Assumes the design package and the source model are compiled first.
`timescale 1ns/100ps
module iss_top_tb_top;
   import iss_pkg::*;
   typedef struct packed {
      logic [3:0] dma;
      logic       xf;
      logic       cp;
      logic       irq;
      logic [6:0] idx;
   } iss_note_type;
   logic               clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
   logic               set_s, lvl_s, probe_s, act;
   logic [7:0]         wb_adr_i;
   logic [3:0]         wb_sel_i;
   logic [31:0]        wb_dat_i, wb_dat_o, block_size_o, rnd, old;
   logic [6:0]         idx_s, s;
   logic [1:0]         ch;
   logic [NUM_SRC-1:0] src_irq_i, xfer_req_o, cpu_req_o;
   logic [NUM_CH-1:0]  dma_req_o;
   int                 fails, checked;
   logic [31:0]        rq[$];
   iss_note_type       pq[$];

   iss_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_irq_i(src_irq_i), .dma_req_o(dma_req_o),
      .xfer_req_o(xfer_req_o), .cpu_req_o(cpu_req_o), .block_size_o(block_size_o),
      .irq_o(irq_o));
   iss_src_model src_u (.clk_i(clk_i), .rst_i(rst_i), .set_i(set_s), .idx_i(idx_s),
      .lvl_i(lvl_s), .src_o(src_irq_i));

   // ==========================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic give_verdict();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
      checked++;
      if (v !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, v);
      end
   endtask
   task automatic cmp_route(input iss_note_type n);
      chk("dma_req", 32'(n.dma), 32'(dma_req_o));
      chk("xfer_req", 32'(n.xf), 32'(xfer_req_o[n.idx]));
      chk("cpu_req", 32'(n.cp), 32'(cpu_req_o[n.idx]));
      chk("irq", 32'(n.irq), 32'(irq_o));
   endtask
   // The bus request is held until ack is seen or 50 edges pass; a later answer ends the run as a failure.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] bs);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= bs;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) begin
         fails++;
         give_verdict();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      wb(1'b0, a, 32'h0, 4'hf);
   endtask
   task automatic look(input logic [3:0] d, input logic x, input logic c, input logic q);
      repeat (2) @(posedge clk_i);
      pq.push_back('{d, x, c, q, s});
      probe_s <= 1'b1;
      @(posedge clk_i);
      probe_s <= 1'b0;
   endtask
   task automatic src(input logic v);
      set_s <= 1'b1;
      idx_s <= s;
      lvl_s <= v;
      @(posedge clk_i);
      set_s <= 1'b0;
   endtask

   // ==========================================================
   // Result watcher
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0) begin
         chk("rd_data", rq.pop_front(), wb_dat_o);
      end
      if (probe_s === 1'b1 && pq.size() > 0) begin
         cmp_route(pq.pop_front());
      end
   end

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // ==========================================================
   // Main sequence
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, set_s, lvl_s, probe_s} = 7'h40;
      {wb_adr_i, wb_sel_i, wb_dat_i, idx_s, s} = '0;
      rnd = 32'hd0edd556;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(OFF_BSIZE, RST_BSIZE);
      chk("block_size", RST_BSIZE, block_size_o);
      wb(1'b1, OFF_XCE_GONE, 32'hffff_ffff, 4'hf);
      rd(OFF_XCE_GONE, 32'h0);
      for (int k = 0; k < XCE_NUM; k++) wb(1'b1, 8'(OFF_XCE_BASE + 4 * k), 32'(16'ha5c3 ^ k), 4'hf);
      for (int k = 0; k < XCE_NUM; k++) rd(8'(OFF_XCE_BASE + 4 * k), 32'(16'ha5c3 ^ k));
      for (int k = 0; k < XCE_NUM; k++) wb(1'b1, 8'(OFF_XCE_BASE + 4 * k), 32'h0, 4'hf);
      rnd = lfsr(rnd);
      old = rnd;
      wb(1'b1, OFF_BSIZE, rnd, 4'hf);
      wb(1'b1, OFF_BSIZE, ~rnd, 4'h3);
      rd(OFF_BSIZE, {old[31:16], ~old[15:0]});
      chk("block_size", {old[31:16], ~old[15:0]}, block_size_o);
      $display("test done: registers");
      rnd = lfsr(rnd);
      s = 7'(rnd % NUM_SRC);
      wb(1'b1, 8'(OFF_XCE_BASE + 4 * (s / 16)), 32'h1 << (s % 16), 4'hf);
      src(1'b1);
      look(4'h0, 1'b1, 1'b0, 1'b0);
      wb(1'b1, 8'(OFF_XCE_BASE + 4 * (s / 16)), 32'h0, 4'hf);
      look(4'h0, 1'b0, 1'b1, 1'b0);
      src(1'b0);
      $display("test done: unclaimed routes");
      rnd = lfsr(rnd);
      ch = rnd[9:8];
      s = 7'(rnd % NUM_SRC);
      wb(1'b1, 8'(OFF_SEL_BASE + 4 * ch), 32'(s), 4'hf);
      src(1'b1);
      for (int m = 0; m < 16; m++) begin
         wb(1'b1, 8'(OFF_MODE_BASE + 4 * ch), 32'(m), 4'hf);
         act = m[3] & ~m[2] & m[1];
         look(4'(act) << ch, 1'b0, ~(act & m[0]), 1'b0);
      end
      src(1'b0);
      $display("test done: channel claim modes");
      wb(1'b1, 8'(OFF_MODE_BASE + 4 * ch), 32'hb, 4'hf);
      wb(1'b1, OFF_STAT, 32'hf, 4'hf);
      src(1'b1);
      look(4'h1 << ch, 1'b0, 1'b0, 1'b0);
      rd(OFF_STAT, 32'h1 << ch);
      wb(1'b1, OFF_MASK, 32'h1 << ch, 4'hf);
      look(4'h1 << ch, 1'b0, 1'b0, 1'b1);
      src(1'b0);
      wb(1'b1, OFF_STAT, 32'h1 << ch, 4'hf);
      look(4'h0, 1'b0, 1'b0, 1'b0);
      rd(OFF_STAT, 32'h0);
      $display("test done: interrupt status and mask");
      give_verdict();
   end
endmodule
